/* File: hdl/schi_host_port.sv */
// Host port of a dual-channel serial controller: register pointer access,
// wait/ready, receive FIFO, transmit buffer, daisy-chain interrupts.
// Assumes every input is synchronous to MCLK, shared with the processor.
`timescale 1ns/10ps
`default_nettype none
`include "schi_params.svh"

module schi_host_port
  import schi_pkg::*;
#(
  parameter int DW = 8
) (
  input  wire logic          MCLK,
  input  wire logic          NRST,
  input  wire schi_bus_t     BUS,
  input  wire logic [DW-1:0] D_IN,
  output logic      [DW-1:0] D_OUT,
  output logic               D_OE,
  output logic               INT_N,
  input  wire logic          PRIORITY_IN,
  output logic               PRIORITY_OUT,
  output logic      [1:0]    WAIT_READY_N,
  input  wire logic [1:0]    CTS_N,
  input  wire logic [1:0]    DCD_N,
  input  wire logic [1:0]    RX_VALID,
  input  wire logic [DW-1:0] RX_DATA_A,
  input  wire logic [DW-1:0] RX_DATA_B,
  input  wire logic [1:0]    TX_TAKE,
  output logic      [19:0]   TX_SHIFT_A,
  output logic      [19:0]   TX_SHIFT_B
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [DW-1:0] wr_q [2][8];          // Write registers per channel
  logic [2:0]    ptr_q [2];            // Register pointers
  logic [DW-1:0] rxf_q [2][`SCHI_RX_DEPTH]; // Receive FIFOs
  logic [1:0]    rxc_q [2];            // FIFO fill counts
  logic [DW-1:0] txb_q [2];            // Transmit data buffers
  logic [1:0]    txf_q;                // Transmit buffer full
  logic [19:0]   txs_q [2];            // Transmit shift registers
  logic [1:0]    ext_q;                // Latched modem changes
  logic [1:0]    cts_q, dcd_q;         // Previous modem levels
  logic [5:0]    ius_q;                // In-service latches
  logic [5:0]    pend_frz_q;           // Pending, frozen during fetch
  logic [DW-1:0] op_q;                 // Last fetched opcode
  schi_op_t      op_st_q;              // Return-opcode snoop state
  logic          rd_q;                 // Previous read strobe

  // Decoded strobes
  logic cyc, wr_acc, rd_acc, ack, fetch, ch;
  logic rd_edge;
  logic [5:0] pend_raw;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // channel and kind
  assign ch     = BUS.chan_b;
  assign cyc    = !BUS.cs_n && !BUS.io_request_n && BUS.opcode_fetch_n;
  assign wr_acc = cyc && BUS.rd_n;
  // A read spans several clocks; act on its first one only
  assign rd_acc = cyc && !BUS.rd_n;
  assign rd_edge = rd_acc && !rd_q;
  assign ack    = !BUS.opcode_fetch_n && !BUS.io_request_n;
  assign fetch  = !BUS.opcode_fetch_n && BUS.io_request_n && !BUS.rd_n;

  function automatic logic is_chan_reset(input logic [DW-1:0] b);
    return b[`SCHI_CMD_MSB:`SCHI_CMD_LSB] == `SCHI_CMD_CHAN_RST;
  endfunction

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_acc;
    end
  end

  // ------------------------------------------------------------
  // Pointer and write registers
  // ------------------------------------------------------------
  // Write strobe qualified to one clock by a delayed copy
  logic wr_q1;
  logic wr_edge;
  assign wr_edge = wr_acc && !wr_q1;
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      wr_q1 <= 1'b0;
    end else begin
      wr_q1 <= wr_acc;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int c = 0; c < 2; c++) begin
        ptr_q[c] <= 3'h0;
        for (int r = 0; r < 8; r++) begin
          wr_q[c][r] <= `SCHI_RST_BYTE;
        end
      end
    end else if (wr_edge && BUS.ctrl) begin
      if (ptr_q[ch] == 3'h0) begin
        wr_q[ch][0] <= D_IN;
        ptr_q[ch] <= D_IN[`SCHI_PTR_MSB:`SCHI_PTR_LSB];
        if (is_chan_reset(D_IN)) begin
          ptr_q[ch] <= 3'h0;
          for (int r = 1; r < 8; r++) begin
            if (r != 2) wr_q[ch][r] <= `SCHI_RST_BYTE;
          end
        end
      end else begin
        // vector register only in channel B
        if (ptr_q[ch] != 3'h2 || ch) begin
          wr_q[ch][ptr_q[ch]] <= D_IN;
        end
        ptr_q[ch] <= 3'h0;
      end
    end else if (rd_edge && BUS.ctrl) begin
      ptr_q[ch] <= 3'h0;
    end
  end

  // ------------------------------------------------------------
  // Receive FIFO
  // ------------------------------------------------------------
  // three entries per channel; overflow drops the newest
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int c = 0; c < 2; c++) begin
        rxc_q[c] <= 2'h0;
        for (int i = 0; i < `SCHI_RX_DEPTH; i++) rxf_q[c][i] <= `SCHI_RST_BYTE;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        logic pop;
        logic push;
        logic [1:0] cnt;
        pop  = rd_edge && !BUS.ctrl && (ch == c[0]) && (rxc_q[c] != 2'h0);
        push = RX_VALID[c] && (rxc_q[c] != 2'(`SCHI_RX_DEPTH) || pop);
        cnt  = rxc_q[c];
        if (pop) begin
          rxf_q[c][0] <= rxf_q[c][1];
          rxf_q[c][1] <= rxf_q[c][2];
          cnt = cnt - 2'h1;
        end
        if (push) begin
          rxf_q[c][cnt] <= (c == 0) ? RX_DATA_A : RX_DATA_B;
          cnt = cnt + 2'h1;
        end
        rxc_q[c] <= cnt;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit buffer and shift register
  // ------------------------------------------------------------
  // buffer loads from bus, shifter from buffer or sync regs
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      txf_q <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        txb_q[c] <= `SCHI_RST_BYTE;
        txs_q[c] <= 20'h0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (TX_TAKE[c]) begin
          txs_q[c] <= txf_q[c] ? {12'h0, txb_q[c]} : {4'h0, wr_q[c][7], wr_q[c][6]};
          txf_q[c] <= 1'b0;
        end
        if (wr_edge && !BUS.ctrl && (ch == c[0])) begin
          txb_q[c] <= D_IN;
          txf_q[c] <= 1'b1;
        end
      end
    end
  end
  assign TX_SHIFT_A = txs_q[0];
  assign TX_SHIFT_B = txs_q[1];

  // ------------------------------------------------------------
  // Modem monitor
  // ------------------------------------------------------------
  // change latched if external interrupts enabled
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ext_q <= 2'h0;
      cts_q <= 2'h0;
      dcd_q <= 2'h0;
    end else begin
      cts_q <= ~CTS_N;
      dcd_q <= ~DCD_N;
      for (int c = 0; c < 2; c++) begin
        if (wr_edge && BUS.ctrl && ch == c[0] && ptr_q[c] == 3'h0) ext_q[c] <= 1'b0;
        if (wr_q[c][1][`SCHI_EXTIE_BIT] && ((cts_q[c] != !CTS_N[c]) || (dcd_q[c] != !DCD_N[c])))
          ext_q[c] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Wait / ready
  // ------------------------------------------------------------
  logic [1:0] can_move;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      can_move[c] = wr_q[c][1][`SCHI_WR_RX_BIT] ? (rxc_q[c] != 2'h0) : !txf_q[c];
      WAIT_READY_N[c] = 1'b1;
      // enable and function bits select mode
      if (wr_q[c][1][`SCHI_WR_EN_BIT]) begin
        if (wr_q[c][1][`SCHI_WR_FN_BIT]) begin
          // ready low when byte can move
          WAIT_READY_N[c] = !can_move[c];
        end else begin
          // wait low while access would stall
          WAIT_READY_N[c] = !(cyc && ch == c[0] && !BUS.ctrl && !can_move[c]);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt daisy chain
  // ------------------------------------------------------------
  // six sources in one chain; index order is priority
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      pend_raw[3*c]   = (wr_q[c][1][`SCHI_RXIE_MSB:`SCHI_RXIE_LSB] != 2'h0) && (rxc_q[c] != 2'h0);
      pend_raw[3*c+1] = wr_q[c][1][`SCHI_TXIE_BIT] && !txf_q[c];
      pend_raw[3*c+2] = ext_q[c];
    end
  end

  // freeze status while fetch is low
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pend_frz_q <= 6'h0;
    end else if (BUS.opcode_fetch_n) begin
      pend_frz_q <= pend_raw & ~ius_q;
    end
  end

  // Highest pending source, returned as index
  function automatic logic [2:0] top_src(input logic [5:0] p);
    top_src = 3'h7;
    for (int i = 5; i >= 0; i--) if (p[i]) top_src = 3'(i);
  endfunction

  logic [2:0]    win;
  logic [DW-1:0] vec;
  logic          chain_low;
  assign win = top_src(pend_frz_q);

  // three bits of vector carry condition
  always_comb begin
    vec = wr_q[1][2];
    if (wr_q[1][1][`SCHI_STAT_AFV_BIT]) begin
      case (win)
        SCHI_SRC_ARX: vec[`SCHI_VEC_MSB:`SCHI_VEC_LSB] = 3'h6;
        SCHI_SRC_ATX: vec[`SCHI_VEC_MSB:`SCHI_VEC_LSB] = 3'h4;
        SCHI_SRC_AEX: vec[`SCHI_VEC_MSB:`SCHI_VEC_LSB] = 3'h5;
        SCHI_SRC_BRX: vec[`SCHI_VEC_MSB:`SCHI_VEC_LSB] = 3'h2;
        SCHI_SRC_BTX: vec[`SCHI_VEC_MSB:`SCHI_VEC_LSB] = 3'h0;
        SCHI_SRC_BEX: vec[`SCHI_VEC_MSB:`SCHI_VEC_LSB] = 3'h1;
        default:      vec[`SCHI_VEC_MSB:`SCHI_VEC_LSB] = 3'h3;
      endcase
    end
  end

  // acknowledge sets in-service; return clears it
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ius_q <= 6'h0;
    end else if (ack && PRIORITY_IN && pend_frz_q != 6'h0 && !(|ius_q)) begin
      ius_q[win] <= 1'b1;
    end else if (op_st_q == SCHI_OP_DONE && PRIORITY_IN && (|ius_q)) begin
      // Only the highest in-service source ends
      ius_q[top_src(ius_q)] <= 1'b0;
    end
  end

  // Opcode snoop: prefix then return byte
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      op_st_q <= SCHI_OP_IDLE;
      op_q    <= `SCHI_RST_BYTE;
    end else if (fetch) begin
      op_q <= D_IN;
      case (op_st_q)
        SCHI_OP_IDLE: op_st_q <= (D_IN == `SCHI_OP_PREFIX) ? SCHI_OP_SEEN : SCHI_OP_IDLE;
        SCHI_OP_SEEN: op_st_q <= (D_IN == `SCHI_OP_RETURN) ? SCHI_OP_DONE :
                                 (D_IN == `SCHI_OP_PREFIX) ? SCHI_OP_SEEN : SCHI_OP_IDLE;
        default:      op_st_q <= SCHI_OP_IDLE;
      endcase
    end else if (op_st_q == SCHI_OP_DONE) begin
      op_st_q <= SCHI_OP_IDLE;
    end
  end

  // chain low on pending or service; prefix hides pending
  assign chain_low = (|ius_q) || ((|pend_frz_q) && op_st_q != SCHI_OP_SEEN);
  assign PRIORITY_OUT = PRIORITY_IN && !chain_low;
  // request low while pending, enabled upstream and none in service
  assign INT_N = !((|pend_frz_q) && PRIORITY_IN && !(|ius_q));

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Data latched at read start so it stands while the strobe is held
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      D_OUT <= `SCHI_RST_BYTE;
    end else if (ack) begin
      D_OUT <= vec;
    end else if (rd_edge && !BUS.ctrl) begin
      D_OUT <= rxf_q[ch][0];
    end else if (rd_edge) begin
      case (ptr_q[ch])
        3'h0:    D_OUT <= {2'h0, ~CTS_N[ch], 1'b0, ~DCD_N[ch], !txf_q[ch],
                           |pend_frz_q, rxc_q[ch] != 2'h0};
        3'h1:    D_OUT <= 8'h01;
        3'h2:    D_OUT <= ch ? vec : 8'h00;
        default: D_OUT <= 8'h00;
      endcase
    end
  end
  // vector only when pending and enabled
  assign D_OE = (rd_acc && rd_q) || (ack && PRIORITY_IN && (|pend_frz_q) && !(|ius_q));

endmodule
`default_nettype wire

/* File: hdl/schi_params.svh */
// Constants for the dual-channel serial controller host interface.
// Assumes inclusion by the package and the top module only.
`ifndef SCHI_PARAMS_SVH
`define SCHI_PARAMS_SVH
`define SCHI_PTR_LSB       0
`define SCHI_PTR_MSB       2
`define SCHI_CMD_LSB       3
`define SCHI_CMD_MSB       5
`define SCHI_CMD_CHAN_RST  3'h3
`define SCHI_WR_LSB        5
`define SCHI_WR_MSB        7
`define SCHI_WR_EN_BIT     7
`define SCHI_WR_FN_BIT     6
`define SCHI_WR_RX_BIT     5
`define SCHI_RXIE_LSB      3
`define SCHI_RXIE_MSB      4
`define SCHI_TXIE_BIT      1
`define SCHI_EXTIE_BIT     0
`define SCHI_STAT_AFV_BIT  2
`define SCHI_VEC_LSB       1
`define SCHI_VEC_MSB       3
`define SCHI_RR0_RXA_BIT   0
`define SCHI_RR0_TXE_BIT   2
`define SCHI_RR0_DCD_BIT   3
`define SCHI_RR0_CTS_BIT   5
`define SCHI_OP_PREFIX     8'hed
`define SCHI_OP_RETURN     8'h4d
`define SCHI_RX_DEPTH      3
`define SCHI_RST_BYTE      8'h00
`endif

/* File: hdl/schi_pkg.sv */
// Types shared by the host interface of the serial controller.
// Assumes the params header sits beside it.
`include "schi_params.svh"
package schi_pkg;
  // Host bus strobes, active low as on the pins; chan_b and ctrl are active-high selects
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic io_request_n;
    logic opcode_fetch_n;
    logic chan_b;
    logic ctrl;
  } schi_bus_t;
  // Interrupt source indices, highest priority first
  typedef enum logic [2:0] {
    SCHI_SRC_ARX = 3'h0,
    SCHI_SRC_ATX = 3'h1,
    SCHI_SRC_AEX = 3'h2,
    SCHI_SRC_BRX = 3'h3,
    SCHI_SRC_BTX = 3'h4,
    SCHI_SRC_BEX = 3'h5
  } schi_src_t;
  // Opcode snoop state
  typedef enum logic [1:0] {
    SCHI_OP_IDLE = 2'h0,
    SCHI_OP_SEEN = 2'h1,
    SCHI_OP_DONE = 2'h2
  } schi_op_t;
endpackage

/* File: tb/schi_host_port_assertions.sv */
// Checker on the host port pins.
// Assumes a bind onto schi_host_port.
`timescale 1ns/10ps
`default_nettype none
module schi_host_port_assertions
  import schi_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic          MCLK,
  input wire logic          NRST,
  input wire schi_bus_t     BUS,
  input wire logic [DW-1:0] D_IN,
  input wire logic          D_OE,
  input wire logic          INT_N,
  input wire logic          PRIORITY_IN,
  input wire logic          PRIORITY_OUT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  chain_low_a: assert property (!PRIORITY_IN |-> !PRIORITY_OUT)
    else $error("chain out high with chain in low");
  new_req_a: assert property ($fell(INT_N) && BUS.opcode_fetch_n |-> !PRIORITY_OUT)
    else $error("chain out high while request pending");
  ack_gate_a: assert property (D_OE && !BUS.opcode_fetch_n |-> PRIORITY_IN && !BUS.io_request_n)
    else $error("vector driven without chain grant");
  no_drive_a: assert property (BUS.rd_n && BUS.opcode_fetch_n |-> !D_OE)
    else $error("bus driven outside read");
  rd_drive_a: assert property ((!BUS.cs_n && !BUS.rd_n && !BUS.io_request_n
    && BUS.opcode_fetch_n) [*2] |-> D_OE)
    else $error("read not driven");
  ack_drive_a: assert property (!BUS.opcode_fetch_n && !BUS.io_request_n && !INT_N
    && PRIORITY_IN |-> D_OE)
    else $error("vector missing in acknowledge");
  freeze_int_a: assert property (!BUS.opcode_fetch_n && $past(!BUS.opcode_fetch_n)
    && BUS.io_request_n && $past(D_IN) != 8'h4d |-> $stable(INT_N))
    else $error("request moved during fetch");
  interrupt_return_opcode_free_a: assert property (!BUS.opcode_fetch_n && D_IN == 8'h4d && $past(D_IN) == 8'h4d
    && INT_N && PRIORITY_IN |-> ##[1:3] (PRIORITY_OUT || !INT_N))
    else $error("service latch not cleared");
endmodule
`default_nettype wire

/* File: tb/schi_host_bus.sv */
// Processor bus master model for the host port.
// Assumes it shares MCLK with the port.
// same clock and phase as the processor
`timescale 1ns/10ps
`default_nettype none
module schi_host_bus
  import schi_pkg::*;
(
  input  wire logic       MCLK,
  output var  schi_bus_t  BUS,
  output var  logic [7:0] D_IN
);
  initial begin
    BUS = 6'h3c;
    D_IN = 8'h00;
  end
  // Hold a strobe pattern for n cycles
  task automatic hold(input logic [5:0] b, input logic [7:0] d, input int n);
    @(negedge MCLK);
    BUS = b;
    D_IN = d;
    repeat (n - 1) @(negedge MCLK);
  endtask
  // Release; inverted data so no stale value lingers
  task automatic rel();
    @(negedge MCLK);
    BUS = 6'h3c;
    D_IN = ~D_IN;
  endtask
  // I/O cycle, address from chan and ctrl
  task automatic io(input logic cb, c, rd, input logic [7:0] d);
    hold({1'b0, ~rd, 1'b0, 1'b1, cb, c}, d, 3);
    rel();
  endtask
  // opcode fetch, used for prefix and return
  task automatic fetch(input logic [7:0] op);
    hold(6'h28, op, 3);
    rel();
  endtask
  // acknowledge: fetch low, request low later
  task automatic ack();
    hold(6'h38, 8'h00, 2);
    hold(6'h30, 8'h00, 3);
    rel();
  endtask
endmodule
`default_nettype wire

/* File: tb/test_serial_ctrl_host_interface.sv */
// Self-checking bench for the host port.
// Assumes the bus model and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_serial_ctrl_host_interface
  import schi_pkg::*;
;
  logic MCLK, NRST, D_OE, INT_N, PRIORITY_IN, PRIORITY_OUT, oe_q, got;
  logic [7:0] D_OUT, D_IN, RX_DATA_A, RX_DATA_B, b[4];
  logic [1:0] WAIT_READY_N, RX_VALID, TX_TAKE, CTS_N, DCD_N;
  logic [19:0] TX_SHIFT_A, TX_SHIFT_B;
  logic [7:0] exp_q[$], mask_q[$];
  schi_bus_t BUS;
  int failures = 0;
  int check_count = 0;
  schi_host_bus i_host (.MCLK(MCLK), .BUS(BUS), .D_IN(D_IN));
  schi_host_port i_dut (.MCLK(MCLK), .NRST(NRST), .BUS(BUS), .D_IN(D_IN), .D_OUT(D_OUT),
    .D_OE(D_OE), .INT_N(INT_N), .PRIORITY_IN(PRIORITY_IN), .PRIORITY_OUT(PRIORITY_OUT),
    .WAIT_READY_N(WAIT_READY_N), .CTS_N(CTS_N), .DCD_N(DCD_N), .RX_VALID(RX_VALID),
    .RX_DATA_A(RX_DATA_A), .RX_DATA_B(RX_DATA_B), .TX_TAKE(TX_TAKE),
    .TX_SHIFT_A(TX_SHIFT_A), .TX_SHIFT_B(TX_SHIFT_B));
  always #20 MCLK = ~MCLK;
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [19:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic cb, input logic [7:0] r, v);
    i_host.io(cb, 1'b1, 1'b0, r);
    i_host.io(cb, 1'b1, 1'b0, v);
  endtask
  task automatic rd(input logic cb, c, input logic [7:0] e, m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    i_host.io(cb, c, 1'b1, 8'h00);
  endtask
  task automatic push(input int ch, input logic [7:0] d);
    @(negedge MCLK);
    RX_VALID[ch] = 1'b1;
    if (ch == 1) RX_DATA_B = d;
    else RX_DATA_A = d;
    @(negedge MCLK);
    RX_VALID = 2'b00;
  endtask
  task automatic await_int(input logic v);
    int i;
    for (i = 0; i < 50 && INT_N !== v; i++) @(negedge MCLK);
    check("request", INT_N, v);
    if (i == 50) final_report();
  endtask
  // Monitor: first cycle of drive flags a result
  always @(posedge MCLK) begin
    oe_q <= D_OE;
    if (D_OE === 1'b1 && oe_q !== 1'b1) got = 1'b1;
  end
  always @(negedge MCLK)
    if (got) begin
      got = 1'b0;
      if (exp_q.size() == 0) check("unasked drive", 1, 0);
      else check("read data", D_OUT & mask_q.pop_front(), exp_q.pop_front());
    end
  initial begin
    repeat (20000) @(posedge MCLK);
    failures++;
    final_report();
  end
  initial begin
    {MCLK, NRST, PRIORITY_IN, RX_VALID, TX_TAKE, got} = 8'h20;
    {CTS_N, DCD_N} = 4'hf;
    RX_DATA_A = 8'h00;
    RX_DATA_B = 8'h00;
    void'($urandom(32'hbedad374));
    repeat (16) @(negedge MCLK);
    check("reset pins", {INT_N, D_OE, WAIT_READY_N, PRIORITY_OUT}, 5'h17);
    NRST = 1'b1;
    i_host.io(1'b0, 1'b1, 1'b0, 8'h18);
    wr(1'b1, 8'h02, 8'h60);
    wr(1'b0, 8'h02, 8'hff);
    i_host.io(1'b1, 1'b1, 1'b0, 8'h02);
    rd(1'b1, 1'b1, 8'h60, 8'hff);
    i_host.io(1'b0, 1'b1, 1'b0, 8'h01);
    rd(1'b0, 1'b1, 8'h01, 8'hff);
    rd(1'b0, 1'b1, 8'h00, 8'h01);
    for (int k = 0; k < 4; k++) begin
      b[k] = 8'($urandom);
      push(0, b[k]);
    end
    rd(1'b0, 1'b1, 8'h01, 8'h01);
    for (int k = 0; k < 3; k++) rd(1'b0, 1'b0, b[k], 8'hff);
    rd(1'b0, 1'b1, 8'h00, 8'h01);
    wr(1'b1, 8'h01, 8'he0);
    check("ready idle", WAIT_READY_N[1], 1'b1);
    push(1, b[3]);
    check("ready rx", WAIT_READY_N[1], 1'b0);
    rd(1'b1, 1'b0, b[3], 8'hff);
    wr(1'b1, 8'h01, 8'hc0);
    check("ready tx", WAIT_READY_N[1], 1'b0);
    i_host.io(1'b1, 1'b0, 1'b0, b[0]);
    check("ready full", WAIT_READY_N[1], 1'b1);
    @(negedge MCLK) TX_TAKE = 2'b10;
    @(negedge MCLK) TX_TAKE = 2'b00;
    check("ready taken", WAIT_READY_N[1], 1'b0);
    check("shift out", TX_SHIFT_B, {12'h0, b[0]});
    wr(1'b1, 8'h01, 8'h80);
    i_host.io(1'b1, 1'b0, 1'b0, b[2]);
    i_host.hold(6'h16, b[2], 2);
    check("wait held", WAIT_READY_N[1], 1'b0);
    TX_TAKE = 2'b10;
    @(negedge MCLK) TX_TAKE = 2'b00;
    check("wait freed", WAIT_READY_N[1], 1'b1);
    check("shift again", TX_SHIFT_B, {12'h0, b[2]});
    i_host.rel();
    wr(1'b1, 8'h01, 8'h14);
    wr(1'b0, 8'h01, 8'h10);
    push(1, b[1]);
    push(0, b[2]);
    await_int(1'b0);
    check("chain pend", PRIORITY_OUT, 1'b0);
    PRIORITY_IN = 1'b0;
    i_host.ack();
    PRIORITY_IN = 1'b1;
    exp_q.push_back(8'h6c);
    mask_q.push_back(8'hff);
    i_host.ack();
    rd(1'b0, 1'b0, b[2], 8'hff);
    check("in service", PRIORITY_OUT, 1'b0);
    i_host.fetch(8'hed);
    i_host.fetch(8'h4d);
    exp_q.push_back(8'h64);
    mask_q.push_back(8'hff);
    i_host.ack();
    rd(1'b1, 1'b0, b[1], 8'hff);
    await_int(1'b1);
    i_host.fetch(8'hed);
    i_host.fetch(8'h4d);
    repeat (2) @(negedge MCLK);
    check("chain free", PRIORITY_OUT, 1'b1);
    // Modem change on channel A with external interrupt enabled
    wr(1'b0, 8'h01, 8'h01);
    @(negedge MCLK);
    CTS_N = 2'b10;
    DCD_N = 2'b01;
    await_int(1'b0);
    exp_q.push_back(8'h6a);
    mask_q.push_back(8'hff);
    i_host.ack();
    rd(1'b0, 1'b1, 8'h24, 8'hff);
    rd(1'b1, 1'b1, 8'h08, 8'h08);
    i_host.io(1'b0, 1'b1, 1'b0, 8'h10);
    i_host.fetch(8'hed);
    i_host.fetch(8'h4d);
    await_int(1'b1);
    repeat (2) @(negedge MCLK);
    check("chain idle", PRIORITY_OUT, 1'b1);
    check("left over", 20'(exp_q.size()), 20'h0);
    final_report();
  end
endmodule
bind schi_host_port schi_host_port_assertions #(.DW(DW)) i_chk (.MCLK(MCLK), .NRST(NRST),
  .BUS(BUS), .D_IN(D_IN), .D_OE(D_OE), .INT_N(INT_N), .PRIORITY_IN(PRIORITY_IN),
  .PRIORITY_OUT(PRIORITY_OUT));
`default_nettype wire
